//--- design/bwpl_lock.sv
// Purpose: Password lock gating writes to critical system-control bits
// Assumes: Single clock clk_sys at 10 MHz, async active-low reset rstn
// Notes:   Lock register at OFS_LOCK, protected bits at OFS_PROT
//
// How it works
// - Mode 00 disables the scheme; 11 and all other codes enable it.
// - Mode field only changes when the same write carries password 11000.
// - Password 10011 opens write access to all protected bits.
// - Password 10101 closes write access to all protected bits.
// - Any other password value causes no protection action.
// - Status bit reads 0 while writable, 1 while protected bits locked.
// - Layout: password [7:3] write-only, status bit 2, mode [1:0].
// - Open and close act only while mode is 11; never alter mode.
// - Access closes itself 32 clocks after opening; reopening restarts count.
// - Protected set: divider setting, watchdog enable, power-down, slow-down.
`timescale 1ns/1ps
`default_nettype none
module bwpl_lock #(
    parameter int OPEN_CLKS = bwpl_pkg::OPEN_CLKS
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // AXI4-Lite write address
    input  wire logic [31:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Protected system-control bits
    output bwpl_pkg::bwpl_prot_t    protBits
);

    localparam int CW = $clog2(OPEN_CLKS + 1);

    function automatic logic isReg(input logic [31:0] a,
                                   input logic [3:0] ofs);
        isReg = (a[31:4] == 28'h0) && (a[3:0] == ofs);
    endfunction

    // Write channel state
    logic                   awHeld_ff, nxt_awHeld;
    logic                   wHeld_ff, nxt_wHeld;
    logic [31:0]            awAddr_ff, nxt_awAddr;
    logic [31:0]            wData_ff, nxt_wData;
    logic                   wLane0_ff, nxt_wLane0;
    logic                   bValid_ff, nxt_bValid;
    logic [1:0]             bResp_ff, nxt_bResp;
    // Read channel state
    logic                   rValid_ff, nxt_rValid;
    logic [31:0]            rData_ff, nxt_rData;
    logic [1:0]             rResp_ff, nxt_rResp;
    // Lock state
    logic [1:0]             mode_ff, nxt_mode;
    logic                   open_ff, nxt_open;
    logic [CW-1:0]          openCnt_ff, nxt_openCnt;
    bwpl_pkg::bwpl_prot_t   prot_ff, nxt_prot;

    logic       doWrite;
    logic       schemeOn;
    logic       locked;
    logic [4:0] pass;

    assign s_axi_awready = !awHeld_ff && !bValid_ff;
    assign s_axi_wready  = !wHeld_ff && !bValid_ff;
    assign s_axi_arready = !rValid_ff;
    assign s_axi_bvalid  = bValid_ff;
    assign s_axi_bresp   = bResp_ff;
    assign s_axi_rvalid  = rValid_ff;
    assign s_axi_rdata   = rData_ff;
    assign s_axi_rresp   = rResp_ff;
    assign protBits      = prot_ff;

    assign doWrite  = awHeld_ff && wHeld_ff && !bValid_ff;
    assign schemeOn = (mode_ff != bwpl_pkg::MODE_OFF);
    assign locked   = schemeOn && !open_ff;
    assign pass     = wData_ff[bwpl_pkg::PASS_MSB:bwpl_pkg::PASS_LSB];

    // Bus handshake
    always_comb begin
        nxt_awHeld = awHeld_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wHeld  = wHeld_ff;
        nxt_wData  = wData_ff;
        nxt_wLane0 = wLane0_ff;
        nxt_bValid = bValid_ff;
        nxt_bResp  = bResp_ff;
        nxt_rValid = rValid_ff;
        nxt_rData  = rData_ff;
        nxt_rResp  = rResp_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_awHeld = 1'b1;
            nxt_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_wHeld  = 1'b1;
            nxt_wData  = s_axi_wdata;
            nxt_wLane0 = s_axi_wstrb[0];
        end
        if (doWrite) begin
            nxt_awHeld = 1'b0;
            nxt_wHeld  = 1'b0;
            nxt_bValid = 1'b1;
            nxt_bResp  = (isReg(awAddr_ff, bwpl_pkg::OFS_LOCK) ||
                          isReg(awAddr_ff, bwpl_pkg::OFS_PROT))
                         ? bwpl_pkg::RESP_OKAY : bwpl_pkg::RESP_SLVERR;
        end
        if (bValid_ff && s_axi_bready) begin
            nxt_bValid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rValid = 1'b1;
            nxt_rResp  = bwpl_pkg::RESP_OKAY;
            nxt_rData  = 32'h0;
            if (isReg(s_axi_araddr, bwpl_pkg::OFS_LOCK)) begin
                // Password field is write-only and reads zero
                nxt_rData[bwpl_pkg::STAT_BIT] = locked;
                nxt_rData[bwpl_pkg::MODE_MSB:bwpl_pkg::MODE_LSB] = mode_ff;
            end else if (isReg(s_axi_araddr, bwpl_pkg::OFS_PROT)) begin
                nxt_rData[bwpl_pkg::DIV_MSB:bwpl_pkg::DIV_LSB] =
                    prot_ff.clockDividerSetting;
                nxt_rData[bwpl_pkg::WDT_BIT] = prot_ff.watchdogEnableBit;
                nxt_rData[bwpl_pkg::PD_BIT]  = prot_ff.powerDownRequest;
                nxt_rData[bwpl_pkg::SD_BIT]  = prot_ff.slowDownRequest;
            end else begin
                nxt_rResp = bwpl_pkg::RESP_SLVERR;
            end
        end else if (rValid_ff && s_axi_rready) begin
            nxt_rValid = 1'b0;
        end
    end

    // Lock and protected bits
    always_comb begin
        nxt_mode    = mode_ff;
        nxt_open    = open_ff;
        nxt_openCnt = openCnt_ff;
        nxt_prot    = prot_ff;
        // Window runs down; expiry closes access
        if (open_ff) begin
            if (openCnt_ff <= CW'(1)) begin
                nxt_open    = 1'b0;
                nxt_openCnt = '0;
            end else begin
                nxt_openCnt = openCnt_ff - CW'(1);
            end
        end
        if (doWrite && wLane0_ff) begin
            if (isReg(awAddr_ff, bwpl_pkg::OFS_LOCK)) begin
                // Mode only follows the data beside the mode password
                unique case (pass)
                    bwpl_pkg::PASS_MODE: begin
                        nxt_mode = wData_ff[bwpl_pkg::MODE_MSB:
                                            bwpl_pkg::MODE_LSB];
                    end
                    bwpl_pkg::PASS_OPEN: begin
                        if (mode_ff == bwpl_pkg::MODE_ON) begin
                            nxt_open    = 1'b1;
                            nxt_openCnt = CW'(OPEN_CLKS);
                        end
                    end
                    bwpl_pkg::PASS_CLOSE: begin
                        if (mode_ff == bwpl_pkg::MODE_ON) begin
                            nxt_open    = 1'b0;
                            nxt_openCnt = '0;
                        end
                    end
                    default: begin
                        // No action on unknown passwords
                    end
                endcase
            end else if (isReg(awAddr_ff, bwpl_pkg::OFS_PROT) &&
                         !locked) begin
                nxt_prot.clockDividerSetting =
                    wData_ff[bwpl_pkg::DIV_MSB:bwpl_pkg::DIV_LSB];
                nxt_prot.watchdogEnableBit = wData_ff[bwpl_pkg::WDT_BIT];
                nxt_prot.powerDownRequest  = wData_ff[bwpl_pkg::PD_BIT];
                nxt_prot.slowDownRequest   = wData_ff[bwpl_pkg::SD_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awHeld_ff  <= 1'b0;
            awAddr_ff  <= 32'h0;
            wHeld_ff   <= 1'b0;
            wData_ff   <= 32'h0;
            wLane0_ff  <= 1'b0;
            bValid_ff  <= 1'b0;
            bResp_ff   <= bwpl_pkg::RESP_OKAY;
            rValid_ff  <= 1'b0;
            rData_ff   <= 32'h0;
            rResp_ff   <= bwpl_pkg::RESP_OKAY;
            mode_ff    <= bwpl_pkg::MODE_RESET;
            open_ff    <= 1'b0;
            openCnt_ff <= '0;
            prot_ff    <= '{clockDividerSetting: bwpl_pkg::DIV_RESET,
                            default: 1'b0};
        end else begin
            awHeld_ff  <= nxt_awHeld;
            awAddr_ff  <= nxt_awAddr;
            wHeld_ff   <= nxt_wHeld;
            wData_ff   <= nxt_wData;
            wLane0_ff  <= nxt_wLane0;
            bValid_ff  <= nxt_bValid;
            bResp_ff   <= nxt_bResp;
            rValid_ff  <= nxt_rValid;
            rData_ff   <= nxt_rData;
            rResp_ff   <= nxt_rResp;
            mode_ff    <= nxt_mode;
            open_ff    <= nxt_open;
            openCnt_ff <= nxt_openCnt;
            prot_ff    <= nxt_prot;
        end
    end

    // Checks
    logic lockWr;
    assign lockWr = doWrite && wLane0_ff &&
                    isReg(awAddr_ff, bwpl_pkg::OFS_LOCK);

    // Window age, kept apart from openCnt_ff so the check stands alone
    logic       openWr;
    logic [7:0] age_ff, nxt_age;
    assign openWr = lockWr && pass == bwpl_pkg::PASS_OPEN &&
                    mode_ff == bwpl_pkg::MODE_ON;
    always_comb begin
        nxt_age = 8'h0;
        if (openWr) begin
            nxt_age = 8'h1;
        end else if (open_ff && age_ff != 8'hff) begin
            nxt_age = age_ff + 8'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            age_ff <= 8'h0;
        end else begin
            age_ff <= nxt_age;
        end
    end

    AST_MODE_ONLY_BY_PASS: assert property (@(posedge clk_sys) disable iff (!rstn)
        (mode_ff != $past(mode_ff)) |-> $past(lockWr &&
            pass == bwpl_pkg::PASS_MODE)) else $error("Mode changed without password");
    AST_OPEN_ACTS: assert property (@(posedge clk_sys) disable iff (!rstn)
        lockWr && pass == bwpl_pkg::PASS_OPEN && mode_ff == bwpl_pkg::MODE_ON
        |=> open_ff && !locked) else $error("Open password did not open");
    AST_CLOSE_ACTS: assert property (@(posedge clk_sys) disable iff (!rstn)
        lockWr && pass == bwpl_pkg::PASS_CLOSE && mode_ff == bwpl_pkg::MODE_ON
        |=> !open_ff) else $error("Close password did not close");
    AST_OTHER_PASS_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
        lockWr && pass != bwpl_pkg::PASS_OPEN && pass != bwpl_pkg::PASS_MODE
        && !open_ff |=> !open_ff) else $error("Stray password opened lock");
    AST_MODE_DISABLES: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode_ff == bwpl_pkg::MODE_OFF |-> !locked)
        else $error("Locked while scheme disabled");
    AST_OPEN_NEEDS_MODE: assert property (@(posedge clk_sys) disable iff (!rstn)
        lockWr && pass == bwpl_pkg::PASS_OPEN && mode_ff != bwpl_pkg::MODE_ON
        && !open_ff |=> !open_ff && $stable(mode_ff))
        else $error("Open acted outside mode 11");
    AST_AUTO_CLOSE: assert property (@(posedge clk_sys) disable iff (!rstn)
        open_ff |-> age_ff != 8'h0 && int'(age_ff) <= OPEN_CLKS)
        else $error("Access open past its window");
    AST_OPEN_HOLDS: assert property (@(posedge clk_sys) disable iff (!rstn)
        open_ff && int'(age_ff) < OPEN_CLKS &&
        !(lockWr && pass == bwpl_pkg::PASS_CLOSE) |=> open_ff)
        else $error("Access closed before its window ended");
    AST_LOCKED_KEEPS: assert property (@(posedge clk_sys) disable iff (!rstn)
        locked |=> $stable(prot_ff) || $past(!locked))
        else $error("Protected bit changed while locked");
    AST_FREE_WRITE_LANDS: assert property (@(posedge clk_sys)
        disable iff (!rstn)
        doWrite && wLane0_ff && isReg(awAddr_ff, bwpl_pkg::OFS_PROT) &&
        !locked |=> prot_ff == $past({
            wData_ff[bwpl_pkg::DIV_MSB:bwpl_pkg::DIV_LSB],
            wData_ff[bwpl_pkg::WDT_BIT], wData_ff[bwpl_pkg::PD_BIT],
            wData_ff[bwpl_pkg::SD_BIT]}))
        else $error("Unlocked write was not stored");

endmodule
`default_nettype wire

//--- design/bwpl_pkg.sv
// Purpose: Shared constants and types for the bit write protection lock
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
`default_nettype none
package bwpl_pkg;

    // Register offsets
    localparam logic [3:0] OFS_LOCK    = 4'h0;
    localparam logic [3:0] OFS_PROT    = 4'h4;

    // Lock register fields
    localparam int PASS_MSB = 7;
    localparam int PASS_LSB = 3;
    localparam int STAT_BIT = 2;
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;

    // Passwords
    localparam logic [4:0] PASS_MODE  = 5'h18;
    localparam logic [4:0] PASS_OPEN  = 5'h13;
    localparam logic [4:0] PASS_CLOSE = 5'h15;

    // Scheme modes
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_ON    = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h3;

    // Protected register fields
    localparam int DIV_MSB = 3;
    localparam int DIV_LSB = 0;
    localparam int WDT_BIT = 4;
    localparam int PD_BIT  = 5;
    localparam int SD_BIT  = 6;
    localparam logic [3:0] DIV_RESET = 4'h0;

    // Automatic close window
    localparam int OPEN_CLKS = 32;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] clockDividerSetting;
        logic       watchdogEnableBit;
        logic       powerDownRequest;
        logic       slowDownRequest;
    } bwpl_prot_t;

endpackage
`default_nettype wire

//--- verif/bwpl_lock_tb.sv
// Purpose: Self-checking bench for the bit write protection lock
// Assumes: Bench is the AXI4-Lite master; OPEN_CLKS left at its default
// Notes:   Lock bytes carry the password in [7:3], the scheme field in [1:0]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [31:0] LOCK = {28'h0, bwpl_pkg::OFS_LOCK};
    localparam logic [31:0] PROT = {28'h0, bwpl_pkg::OFS_PROT};
    localparam logic [1:0]  OK   = bwpl_pkg::RESP_OKAY;
    localparam logic [7:0]  OPNB = {bwpl_pkg::PASS_OPEN, 3'h0};
    localparam logic [7:0]  CLSB = {bwpl_pkg::PASS_CLOSE, 3'h0};
    logic                 clk_sys, rstn, awValid, wValid, bReady;
    logic                 arValid, rReady, awReady, wReady, bValid;
    logic                 arReady, rValid;
    logic [31:0]          awAddr, wData, arAddr, rData;
    logic [3:0]           wStrb;
    logic [1:0]           bResp, rResp;
    bwpl_pkg::bwpl_prot_t protBits;
    int                   err_count, n_checks, cyc;

    bwpl_lock #(.OPEN_CLKS(bwpl_pkg::OPEN_CLKS)) uut (
        .clk_sys(clk_sys), .rstn(rstn),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .protBits(protBits));

    task automatic summarize;
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Protected register byte to output struct
    function automatic bwpl_pkg::bwpl_prot_t pv(input logic [7:0] d);
        return '{d[3:0], d[4], d[5], d[6]};
    endfunction

    task automatic chkp(input logic [7:0] d);
        chk("protBits", {25'h0, pv(d)}, {25'h0, protBits});
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        awAddr  <= a;
        wData   <= {24'h0, d};
        wStrb   <= s;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (!aw && awReady === 1'b1) begin
                aw = 1'b1;
                awValid <= 1'b0;
            end
            if (!w && wReady === 1'b1) begin
                w = 1'b1;
                wValid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (bValid !== 1'b1);
        bReady <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bResp});
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] e,
                      input logic [1:0] er);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        do @(posedge clk_sys); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge clk_sys); while (rValid !== 1'b1);
        rReady <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, rResp});
        if (er == OK)
            chk("rdata", {24'h0, e}, rData);
        @(posedge clk_sys);
    endtask

    task automatic t_locked;
        logic [4:0] pw [4] = '{5'h00, 5'h1f, 5'h19, 5'h17};
        wr(PROT, 8'h7f, 4'hf, OK);
        chkp(8'h00);
        foreach (pw[i]) begin
            wr(LOCK, {pw[i], 3'h0}, 4'hf, OK);
            rd(LOCK, 8'h07, OK);
        end
    endtask

    task automatic t_open;
        wr(LOCK, OPNB, 4'hf, OK);
        rd(LOCK, 8'h03, OK);
        wr(PROT, 8'h5a, 4'hf, OK);
        chkp(8'h5a);
        rd(PROT, 8'h5a, OK);
        wr(PROT, 8'h25, 4'h0, OK);
        chkp(8'h5a);
        wr(PROT, 8'h25, 4'hf, OK);
        chkp(8'h25);
        wr(LOCK, CLSB, 4'hf, OK);
        rd(LOCK, 8'h07, OK);
        wr(PROT, 8'h7f, 4'hf, OK);
        chkp(8'h25);
    endtask

    // Margins of several cycles either side of the close point
    task automatic t_auto;
        wr(LOCK, OPNB, 4'hf, OK);
        repeat (24) @(posedge clk_sys);
        rd(LOCK, 8'h03, OK);
        repeat (8) @(posedge clk_sys);
        rd(LOCK, 8'h07, OK);
        wr(LOCK, OPNB, 4'hf, OK);
        repeat (20) @(posedge clk_sys);
        wr(LOCK, OPNB, 4'hf, OK);
        repeat (20) @(posedge clk_sys);
        rd(LOCK, 8'h03, OK);
        repeat (12) @(posedge clk_sys);
        rd(LOCK, 8'h07, OK);
    endtask

    task automatic t_mode;
        wr(LOCK, {bwpl_pkg::PASS_MODE, 1'b0, bwpl_pkg::MODE_OFF}, 4'hf, OK);
        rd(LOCK, 8'h00, OK);
        wr(PROT, 8'h0f, 4'hf, OK);
        chkp(8'h0f);
        wr(LOCK, CLSB, 4'hf, OK);
        rd(LOCK, 8'h00, OK);
        wr(LOCK, {bwpl_pkg::PASS_MODE, 3'h1}, 4'hf, OK);
        rd(LOCK, 8'h05, OK);
        wr(PROT, 8'h70, 4'hf, OK);
        chkp(8'h0f);
        wr(LOCK, OPNB, 4'hf, OK);
        rd(LOCK, 8'h05, OK);
        wr(LOCK, {bwpl_pkg::PASS_MODE, 1'b0, bwpl_pkg::MODE_ON}, 4'hf, OK);
        rd(LOCK, 8'h07, OK);
        wr(32'h10, 8'hff, 4'hf, bwpl_pkg::RESP_SLVERR);
        rd(32'h10, 8'h00, bwpl_pkg::RESP_SLVERR);
        chkp(8'h0f);
    endtask

    // Reset in mid-run must drop an open window
    task automatic t_rst2;
        wr(LOCK, OPNB, 4'hf, OK);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(LOCK, 8'h07, OK);
        chkp(8'h00);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        {rstn, awValid, wValid, bReady, arValid, rReady} = 6'h00;
        {awAddr, wData, arAddr} = 96'h0;
        wStrb = 4'h0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(LOCK, 8'h07, OK);
        rd(PROT, 8'h00, OK);
        chkp(8'h00);
        t_locked();
        t_open();
        t_auto();
        t_mode();
        t_rst2();
        summarize();
    end
endmodule
`default_nettype wire
